// ### verilog/fifo_flag_map.svh
// Register offsets, field positions, reset values and event bit positions
`ifndef FIFO_FLAG_MAP_SVH
`define FIFO_FLAG_MAP_SVH

`define OFFS_ADDR       8'h00
`define FLAGS_ADDR      8'h04
`define ISTAT_ADDR      8'h08
`define IMASK_ADDR      8'h0C

`define EMPTY_OFFS_LSB  0
`define FULL_OFFS_LSB   16
`define OFFS_W          16
`define EMPTY_OFFS_RST  16'h0007
`define FULL_OFFS_RST   16'h0007

`define FLAG_EMPTY_N    0
`define FLAG_FULL_N     1
`define FLAG_AEMPTY_N   2
`define FLAG_AFULL_N    3

`define EV_BECAME_FULL  0
`define EV_BECAME_EMPTY 1
`define EV_WRITE_DROP   2
`define EV_READ_DROP    3
`define EV_W            4
`define IMASK_RST       4'h0

`endif

// ### verilog/fifo_flag_pkg.sv
// Types shared by the flag logic
`default_nettype none
package fifo_flag_pkg;
   typedef enum {
      SEL_OFFS,
      SEL_FLAGS,
      SEL_ISTAT,
      SEL_IMASK,
      SEL_NONE
   } reg_sel_e;
endpackage : fifo_flag_pkg
`default_nettype wire

// ### verilog/fifo_flag_logic.sv
// FIFO storage with full, empty and programmable almost flags, APB registers
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_flag_map.svh"

module fifo_flag_logic #(
   parameter int WIDTH  = 9,
   parameter int ADDR_W = 6
) (
   input  wire logic              SYS_CLK_I,
   input  wire logic              RESET_N_I,
   input  wire logic              PSEL_I,
   input  wire logic              PENABLE_I,
   input  wire logic              PWRITE_I,
   input  wire logic [7:0]        PADDR_I,
   input  wire logic [31:0]       PWDATA_I,
   output logic      [31:0]       PRDATA_O,
   output logic                   PREADY_O,
   output logic                   PSLVERR_O,
   input  wire logic [WIDTH-1:0]  WRITE_DATA_I,
   input  wire logic              WRITE_ENABLE_PRIMARY_N_I,
   input  wire logic              WRITE_ENABLE_SECONDARY_OR_LOAD_I,
   input  wire logic              READ_ENABLE_A_N_I,
   input  wire logic              READ_ENABLE_B_N_I,
   output logic      [WIDTH-1:0]  READ_DATA_O,
   output logic                   FULL_INDICATOR_N_O,
   output logic                   EMPTY_INDICATOR_N_O,
   output logic                   ALMOST_EMPTY_INDICATOR_N_O,
   output logic                   ALMOST_FULL_INDICATOR_N_O,
   output logic                   IRQ_O
);

   localparam int DEPTH = 1 << ADDR_W;
   localparam int CNT_W = ADDR_W + 1;
   localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [CNT_W-1:0] bin2gray(input logic [CNT_W-1:0] b);
      bin2gray = b ^ (b >> 1);
   endfunction : bin2gray

   function automatic logic [CNT_W-1:0] gray2bin(input logic [CNT_W-1:0] g);
      logic [CNT_W-1:0] b;
      b = '0;
      b[CNT_W-1] = g[CNT_W-1];
      for (int i = CNT_W - 2; i >= 0; i--) begin
         b[i] = g[i] ^ b[i+1];
      end
      gray2bin = b;
   endfunction : gray2bin

   function automatic fifo_flag_pkg::reg_sel_e decode(input logic [7:0] a);
      case (a)
         `OFFS_ADDR:  decode = fifo_flag_pkg::SEL_OFFS;
         `FLAGS_ADDR: decode = fifo_flag_pkg::SEL_FLAGS;
         `ISTAT_ADDR: decode = fifo_flag_pkg::SEL_ISTAT;
         `IMASK_ADDR: decode = fifo_flag_pkg::SEL_IMASK;
         default:     decode = fifo_flag_pkg::SEL_NONE;
      endcase
   endfunction : decode

   ////////////////////////////////////////////////////////////////////////////
   // State

   logic [WIDTH-1:0]       mem [DEPTH];
   logic [CNT_W-1:0]       wptr_reg, wptr_next, wgray_reg, wgray_next;
   logic [CNT_W-1:0]       rptr_reg, rptr_next, rgray_reg, rgray_next;
   logic [CNT_W-1:0]       wq1_reg, wq2_reg, rq1_reg, rq2_reg;
   logic                   full_n_reg, full_n_next, afull_n_reg, afull_n_next;
   logic                   empty_n_reg, empty_n_next, aempty_n_reg, aempty_n_next;
   logic [WIDTH-1:0]       rdata_reg, rdata_next;
   logic [`OFFS_W-1:0]     eoffs_reg, eoffs_next, foffs_reg, foffs_next;
   logic [`EV_W-1:0]       istat_reg, istat_next, imask_reg, imask_next;
   logic [31:0]            prdata_reg, prdata_next;
   logic                   wr_try, rd_try, wr_go, rd_go;
   logic [CNT_W-1:0]       wcount, rcount;
   logic [`EV_W-1:0]       events;
   fifo_flag_pkg::reg_sel_e sel;
   logic                   setup, access;

   ////////////////////////////////////////////////////////////////////////////
   // Write side

   always_comb begin
      wr_try = ~WRITE_ENABLE_PRIMARY_N_I & WRITE_ENABLE_SECONDARY_OR_LOAD_I;
      wr_go = wr_try & full_n_reg;
      wptr_next = wr_go ? wptr_reg + 1'b1 : wptr_reg;
      wgray_next = bin2gray(wptr_next);
      // Count against the synchronised read pointer: conservative, never overfills
      wcount = wptr_next - gray2bin(rq2_reg);
      full_n_next = (wcount != DEPTH_C);
      afull_n_next = ({1'b0, `OFFS_W'(wcount)} + {1'b0, foffs_reg}) < {1'b0, `OFFS_W'(DEPTH)};
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (wr_go) begin
         mem[wptr_reg[ADDR_W-1:0]] <= WRITE_DATA_I;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read side

   always_comb begin
      rd_try = ~READ_ENABLE_A_N_I & ~READ_ENABLE_B_N_I;
      rd_go = rd_try & empty_n_reg;
      rptr_next = rd_go ? rptr_reg + 1'b1 : rptr_reg;
      rgray_next = bin2gray(rptr_next);
      rdata_next = rd_go ? mem[rptr_reg[ADDR_W-1:0]] : rdata_reg;
      rcount = gray2bin(wq2_reg) - rptr_next;
      empty_n_next = (rgray_next != wq2_reg);
      aempty_n_next = `OFFS_W'(rcount) > eoffs_reg;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pointers, synchronisers and flags

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         wptr_reg     <= '0;
         wgray_reg    <= '0;
         rptr_reg     <= '0;
         rgray_reg    <= '0;
         wq1_reg      <= '0;
         wq2_reg      <= '0;
         rq1_reg      <= '0;
         rq2_reg      <= '0;
         full_n_reg   <= 1'b1;
         afull_n_reg  <= 1'b1;
         empty_n_reg  <= 1'b0;
         aempty_n_reg <= 1'b0;
         rdata_reg    <= '0;
      end else begin
         wptr_reg     <= wptr_next;
         wgray_reg    <= wgray_next;
         rptr_reg     <= rptr_next;
         rgray_reg    <= rgray_next;
         wq1_reg      <= wgray_reg;
         wq2_reg      <= wq1_reg;
         rq1_reg      <= rgray_reg;
         rq2_reg      <= rq1_reg;
         full_n_reg   <= full_n_next;
         afull_n_reg  <= afull_n_next;
         empty_n_reg  <= empty_n_next;
         aempty_n_reg <= aempty_n_next;
         rdata_reg    <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave and interrupts

   always_comb begin
      sel = decode(PADDR_I);
      setup = PSEL_I & ~PENABLE_I;
      access = PSEL_I & PENABLE_I;
      eoffs_next = eoffs_reg;
      foffs_next = foffs_reg;
      imask_next = imask_reg;
      if (access && PWRITE_I && sel == fifo_flag_pkg::SEL_OFFS) begin
         eoffs_next = PWDATA_I[`EMPTY_OFFS_LSB +: `OFFS_W];
         foffs_next = PWDATA_I[`FULL_OFFS_LSB +: `OFFS_W];
      end
      if (access && PWRITE_I && sel == fifo_flag_pkg::SEL_IMASK) begin
         imask_next = PWDATA_I[`EV_W-1:0];
      end
      events = '0;
      events[`EV_BECAME_FULL]  = full_n_reg & ~full_n_next;
      events[`EV_BECAME_EMPTY] = empty_n_reg & ~empty_n_next;
      events[`EV_WRITE_DROP]   = wr_try & ~full_n_reg;
      events[`EV_READ_DROP]    = rd_try & ~empty_n_reg;
      // Only bits that the read returned are cleared: an event landing between the
      // setup capture and the access edge would otherwise vanish unreported
      // A new event in the clearing cycle survives the read
      istat_next = istat_reg;
      if (access && !PWRITE_I && sel == fifo_flag_pkg::SEL_ISTAT) begin
         istat_next = istat_reg & ~prdata_reg[`EV_W-1:0];
      end
      istat_next = istat_next | events;
      // Read data is captured in the setup cycle so the access has no wait state
      prdata_next = prdata_reg;
      if (setup && !PWRITE_I) begin
         case (sel)
            fifo_flag_pkg::SEL_OFFS:  prdata_next = {foffs_reg, eoffs_reg};
            fifo_flag_pkg::SEL_FLAGS: prdata_next = {28'h0000000, afull_n_reg, aempty_n_reg, full_n_reg, empty_n_reg};
            fifo_flag_pkg::SEL_ISTAT: prdata_next = {28'h0000000, istat_reg};
            fifo_flag_pkg::SEL_IMASK: prdata_next = {28'h0000000, imask_reg};
            default:                  prdata_next = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (!RESET_N_I) begin
         eoffs_reg  <= `EMPTY_OFFS_RST;
         foffs_reg  <= `FULL_OFFS_RST;
         istat_reg  <= '0;
         imask_reg  <= `IMASK_RST;
         prdata_reg <= 32'h00000000;
      end else begin
         eoffs_reg  <= eoffs_next;
         foffs_reg  <= foffs_next;
         istat_reg  <= istat_next;
         imask_reg  <= imask_next;
         prdata_reg <= prdata_next;
      end
   end

   assign PRDATA_O = prdata_reg;
   assign PREADY_O = 1'b1;
   assign PSLVERR_O = access & (sel == fifo_flag_pkg::SEL_NONE);
   assign IRQ_O = |(istat_reg & imask_reg);
   assign READ_DATA_O = rdata_reg;
   assign FULL_INDICATOR_N_O = full_n_reg;
   assign EMPTY_INDICATOR_N_O = empty_n_reg;
   assign ALMOST_EMPTY_INDICATOR_N_O = aempty_n_reg;
   assign ALMOST_FULL_INDICATOR_N_O = afull_n_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RESET_N_I);

   sequence seq_write_blocked;
      !full_n_reg && wr_try;
   endsequence

   sequence seq_read_blocked;
      !empty_n_reg && rd_try;
   endsequence

   AST_FULL_BLOCKS: assert property (seq_write_blocked |=> wptr_reg == $past(wptr_reg))
      else $error("write taken while full");
   AST_EMPTY_BLOCKS: assert property (seq_read_blocked |=> rptr_reg == $past(rptr_reg))
      else $error("read taken while empty");
   AST_FULL_LEVEL: assert property (!full_n_reg |-> (wptr_reg - gray2bin($past(rq2_reg))) == DEPTH_C)
      else $error("full indicator without full storage");
   AST_EMPTY_LEVEL: assert property (!empty_n_reg |-> $past(wq2_reg) == rgray_reg)
      else $error("empty indicator with unread words");
   AST_FULL_CAUSE: assert property ($fell(full_n_reg) |-> $past(wr_go))
      else $error("full indicator fell without a write");
   AST_EMPTY_CAUSE: assert property ($fell(empty_n_reg) |-> $past(rd_go))
      else $error("empty indicator fell without a read");
   AST_WRITE_STEP: assert property (wr_go |=> wptr_reg == $past(wptr_reg) + 1'b1)
      else $error("write pointer did not advance by one");
   AST_READ_STEP: assert property (rd_go |=> rptr_reg == $past(rptr_reg) + 1'b1
      ##0 rdata_reg == $past(mem[rptr_reg[ADDR_W-1:0]]))
      else $error("read did not deliver one word");
   AST_AEMPTY_LEVEL: assert property (aempty_n_reg |->
      `OFFS_W'(gray2bin($past(wq2_reg)) - rptr_reg) > $past(eoffs_reg))
      else $error("almost-empty high at or below offset");
   AST_AFULL_LEVEL: assert property (!afull_n_reg |->
      ({1'b0, `OFFS_W'(wptr_reg - gray2bin($past(rq2_reg)))} + {1'b0, $past(foffs_reg)}) >= {1'b0, `OFFS_W'(DEPTH)})
      else $error("almost-full low below threshold");
   AST_SYNC_DELAY: assert property ($changed(wgray_reg) |-> ##2 wq2_reg == $past(wgray_reg, 2))
      else $error("write pointer did not cross in two cycles");
   AST_FLAGS_REGISTERED: assert property (FULL_INDICATOR_N_O == $past(full_n_next)
      && EMPTY_INDICATOR_N_O == $past(empty_n_next) && ALMOST_EMPTY_INDICATOR_N_O == $past(aempty_n_next)
      && ALMOST_FULL_INDICATOR_N_O == $past(afull_n_next))
      else $error("flag output not from flip-flop");

   // True pointers: a wrap past the depth or a read overtaking the writer shows as a count above it
   AST_NO_OVERRUN: assert property ((wptr_reg - rptr_reg) <= DEPTH_C)
      else $error("occupancy outside zero to depth");
   AST_WRITE_STORES: assert property (wr_go |=> mem[$past(wptr_reg[ADDR_W-1:0])] == $past(WRITE_DATA_I))
      else $error("accepted word not stored");
   AST_READ_HOLDS: assert property (!rd_go |=> $stable(rdata_reg))
      else $error("read data changed without a read");
   AST_AEMPTY_LOW: assert property (!aempty_n_reg |->
      `OFFS_W'(gray2bin($past(wq2_reg)) - rptr_reg) <= $past(eoffs_reg))
      else $error("almost-empty low above offset");
   AST_AFULL_HIGH: assert property (afull_n_reg |->
      ({1'b0, `OFFS_W'(wptr_reg - gray2bin($past(rq2_reg)))} + {1'b0, $past(foffs_reg)}) < {1'b0, `OFFS_W'(DEPTH)})
      else $error("almost-full high at threshold");

   sequence seq_status_read;
      PSEL_I && PENABLE_I && !PWRITE_I && sel == fifo_flag_pkg::SEL_ISTAT;
   endsequence

   AST_STATUS_SET: assert property ((events != '0) |=> (istat_reg & $past(events)) == $past(events))
      else $error("status event lost");
   AST_STATUS_CLEAR: assert property (seq_status_read |=>
      (istat_reg & $past(prdata_reg[`EV_W-1:0]) & ~$past(events)) == '0)
      else $error("reported status bit not cleared");

endmodule : fifo_flag_logic

`default_nettype wire

// ### dv/fifo_agent_model.sv
// Far-side agent: system logic that writes words into and reads words out of the FIFO
`timescale 1ns/1ps
`default_nettype none
module fifo_agent_model (
   input  wire logic       clk_i,
   input  wire logic       wr_req_i,
   input  wire logic [1:0] wr_pins_i,
   input  wire logic [8:0] wr_word_i,
   input  wire logic       rd_req_i,
   input  wire logic [1:0] rd_pins_i,
   output logic            pri_n_o,
   output logic            sec_o,
   output logic [8:0]      data_o,
   output logic            rd_a_n_o,
   output logic            rd_b_n_o
);
   logic [8:0] idle_reg = 9'h0AA;
   // Idle data line repeats the last word written for one cycle, then toggles each cycle
   always @(posedge clk_i) begin
      idle_reg <= wr_req_i ? wr_word_i : ~idle_reg;
   end
   always_comb begin
      pri_n_o  = wr_req_i ? wr_pins_i[1] : 1'b1;
      sec_o    = wr_req_i ? wr_pins_i[0] : 1'b0;
      data_o   = wr_req_i ? wr_word_i : idle_reg;
      rd_a_n_o = rd_req_i ? rd_pins_i[1] : 1'b1;
      rd_b_n_o = rd_req_i ? rd_pins_i[0] : 1'b1;
   end
endmodule : fifo_agent_model
`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the FIFO flag logic
`timescale 1ns/1ps
`default_nettype none
`include "fifo_flag_map.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
   $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module testbench;
   logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, err, wr_req, rd_req;
   logic        pri_n, sec, ra_n, rb_n, full_n, empty_n, ae_n, af_n;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic [1:0]  wr_pins, rd_pins;
   logic [8:0]  wr_word, din, dout, exp_word;
   logic [8:0]  q[$];
   int          failures, checks_done, cycles, n, m;
   fifo_flag_logic dut_u (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .WRITE_DATA_I(din), .WRITE_ENABLE_PRIMARY_N_I(pri_n),
      .WRITE_ENABLE_SECONDARY_OR_LOAD_I(sec), .READ_ENABLE_A_N_I(ra_n), .READ_ENABLE_B_N_I(rb_n),
      .READ_DATA_O(dout), .FULL_INDICATOR_N_O(full_n), .EMPTY_INDICATOR_N_O(empty_n),
      .ALMOST_EMPTY_INDICATOR_N_O(ae_n), .ALMOST_FULL_INDICATOR_N_O(af_n), .IRQ_O(irq));
   fifo_agent_model agent_u (.clk_i(clk), .wr_req_i(wr_req), .wr_pins_i(wr_pins), .wr_word_i(wr_word),
      .rd_req_i(rd_req), .rd_pins_i(rd_pins), .pri_n_o(pri_n), .sec_o(sec), .data_o(din),
      .rd_a_n_o(ra_n), .rd_b_n_o(rb_n));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // No cycle count assumed here: only the bench timeout ends a wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic flags(input bit w, input bit r);
      if (w) `CHK({full_n, af_n}, {1'(q.size() != 64), 1'(q.size() < 64 - m)})
      if (r) `CHK({empty_n, ae_n}, {1'(q.size() != 0), 1'(q.size() > n)})
   endtask : flags
   // Drive one cycle; check what the previous cycle's request left behind
   task automatic step(input logic w, input logic r, input bit f);
      logic [1:0] wp, rp;
      logic [8:0] wd;
      wp = f ? 2'b01 : {1'($urandom % 4 == 0), 1'($urandom % 4 != 0)};
      rp = {1'($urandom % 4 == 0), 1'($urandom % 4 == 0)};
      wd = 9'($urandom);
      @(posedge clk);
      wr_req <= w;
      wr_pins <= wp;
      wr_word <= wd;
      rd_req <= r;
      rd_pins <= rp;
      @(negedge clk);
      if (w) flags(1, 0);
      if (r) `CHK({empty_n, dout}, {1'(q.size() != 0), exp_word})
      if (w && wp == 2'b01 && q.size() < 64) q.push_back(wd);
      if (r && rp == 2'b00 && q.size() > 0) exp_word = q.pop_front();
   endtask : step
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_n, psel, penable, pwrite, paddr, pwdata, wr_req, rd_req, wr_pins, rd_pins} = '0;
      wr_word = 9'h000;
      exp_word = 9'h000;
      void'($urandom(32'h987FEFA0));
      n = 7;
      m = 7;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      step(0, 0, 0);
      flags(1, 1);
      apb(0, `OFFS_ADDR, 0);
      `CHK(rdv, 32'h0007_0007)
      n = 1 + $urandom % 15;
      m = 1 + $urandom % 15;
      apb(1, `OFFS_ADDR, {16'(m), 16'(n)});
      apb(1, `IMASK_ADDR, 32'h0000_000F);
      apb(0, `OFFS_ADDR, 0);
      `CHK(rdv, {16'(m), 16'(n)})
      apb(0, `IMASK_ADDR, 0);
      `CHK(rdv, 32'h0000_000F)
      $display("test reset and offsets done");
      repeat (160) step(1, 0, 0);
      repeat (8) step(0, 0, 0);
      flags(1, 1);
      `CHK(irq, 1'b1)
      apb(0, `ISTAT_ADDR, 0);
      `CHK(rdv[3:0] & 4'hD, 4'h5)
      repeat (2) step(0, 0, 0);
      `CHK(irq, 1'b0)
      apb(1, `IMASK_ADDR, 0);
      $display("test fill done");
      repeat (160) step(0, 1, 0);
      repeat (8) step(0, 0, 0);
      flags(1, 1);
      `CHK(irq, 1'b0)
      apb(1, `IMASK_ADDR, 32'h0000_0008);
      repeat (2) step(0, 0, 0);
      `CHK(irq, 1'b1)
      apb(0, `ISTAT_ADDR, 0);
      `CHK(rdv[3:0], 4'hA)
      repeat (2) step(0, 0, 0);
      `CHK(irq, 1'b0)
      $display("test drain done");
      repeat (n) step(1, 0, 1);
      repeat (8) step(0, 0, 0);
      flags(1, 1);
      step(1, 0, 1);
      repeat (8) step(0, 0, 0);
      flags(1, 1);
      apb(0, `FLAGS_ADDR, 0);
      `CHK(rdv[3:0], {1'(q.size() < 64 - m), 1'(q.size() > n), 1'(q.size() != 64), 1'(q.size() != 0)})
      apb(0, 8'h10, 0);
      `CHK({err, rdv}, {1'b1, 32'h0000_0000})
      $display("test boundaries and registers done");
      conclude();
   end
endmodule : testbench
`default_nettype wire
